// ---- rtl/pws_pkg.sv ----
`default_nettype none
package pws_pkg;
  // One-second tick derived from the system clock.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_DEF = CLK_HZ * TICK_S;
  localparam logic [5:0] SEC_PER_MIN = 6'h3C;
  localparam logic [7:0] PAUSE_S = 8'h01;
  localparam logic [1:0] CUT_S = 2'h2;
  // Setting limits and reset values; index values are in units of 0.0001.
  localparam logic [15:0] PRE_MAX = 16'h003C;
  localparam logic [15:0] PRE_DEF = 16'h0000;
  localparam logic [15:0] REC_MAX = 16'h0078;
  localparam logic [15:0] REC_DEF = 16'h0014;
  localparam logic [15:0] WASH_MAX = 16'h001E;
  localparam logic [15:0] WASH_DEF = 16'h0003;
  localparam logic [15:0] INT_MAX = 16'h05A0;
  localparam logic [15:0] INT_DEF = 16'h0014;
  localparam logic [15:0] TOL_MAX = 16'h05A0;
  localparam logic [15:0] TOL_DEF = 16'h0000;
  localparam logic [15:0] TEMP_MAX = 16'h00C8;
  localparam logic [15:0] TEMP_DEF = 16'h0000;
  localparam logic [15:0] VLIM_MIN = 16'h2CEC;
  localparam logic [15:0] VLIM_MAX = 16'h4650;
  localparam logic [15:0] VLIM_DEF = 16'h34BC;
  localparam logic [15:0] DELTA_MAX = 16'h1388;
  localparam logic [15:0] DELTA_DEF = 16'h0000;
  // Register byte offsets.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PRE = 8'h04;
  localparam logic [7:0] A_REC = 8'h08;
  localparam logic [7:0] A_WASH = 8'h0C;
  localparam logic [7:0] A_INT = 8'h10;
  localparam logic [7:0] A_TOL = 8'h14;
  localparam logic [7:0] A_TEMP = 8'h18;
  localparam logic [7:0] A_VLIM = 8'h1C;
  localparam logic [7:0] A_DELTA = 8'h20;
  localparam logic [7:0] A_STAT = 8'h24;
  // Control register fields.
  localparam int unsigned C_MANUAL = 0;
  localparam int unsigned C_PRE_RLY = 1;
  localparam int unsigned C_WASH_RLY = 2;
  localparam int unsigned C_GUARD = 3;
  localparam int unsigned C_MHOLD = 4;
  localparam int unsigned C_THOLD = 5;
  localparam int unsigned C_LOWT = 6;
  localparam int unsigned C_VM = 8;
  localparam logic [9:0] CTRL_DEF = 10'h01E;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_DEC = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PRE = 3'b001, ST_PAUSE = 3'b010, ST_WASH = 3'b011, ST_REC = 3'b100
  } pws_phase_t;
  typedef enum logic [1:0] {VM_OFF = 2'b00, VM_STD = 2'b01, VM_CUT = 2'b10} pws_vmode_t;
  typedef struct packed {
    logic [15:0] concentration_reading;
    logic [15:0] loop;
    logic [15:0] temp;
  } pws_meas_t;
  typedef struct packed {
    pws_phase_t ph;
    logic [7:0] ph_cnt;
    logic [31:0] presc;
    logic tick;
    logic [5:0] int_sec;
    logic [10:0] int_min;
    logic [5:0] tol_sec;
    logic [10:0] tol_min;
    logic man_p;
    logic ext_p;
    logic int_p;
    logic ext_prev;
    logic [1:0] src;
    logic [15:0] lim;
    logic accepted;
    logic cut_armed;
    logic [1:0] cut_cnt;
    logic warn;
    logic fail;
    logic pre_rly;
    logic wash_rly;
    pws_meas_t mout;
    logic [9:0] ctrl;
    logic [15:0] pre_t;
    logic [15:0] rec_t;
    logic [15:0] wash_t;
    logic [15:0] int_t;
    logic [15:0] tol_t;
    logic [15:0] temp_lim;
    logic [15:0] vlim;
    logic [15:0] delta;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pws_state_t;
endpackage
`default_nettype wire

// ---- rtl/pws_top.sv ----
// What this block does
// - A rising external clean request starts one cycle; holding it high starts no more.
// - No cycle starts without sensor or with a faulty sensor, nor without sample while the guard is on.
// - Precondition time is 0 to 60 seconds, reset value 0.
// - Recovery time is 0 to 120 seconds, reset value 20.
// - Wash time is 0 to 30 seconds, reset value 3.
// - Interval is 0 to 1440 minutes, reset value 20; elapsing starts a cycle.
// - A zero interval never starts a cycle.
// - Zero precondition time or no precondition relay skips that phase.
// - Zero wash time or no wash relay disables washing and ignores triggers.
// - Verify mode is off, standard or automatic cut; off after reset.
// - Standard verify accepts when index drops below limit or sample vanishes.
// - With verify on, an unaccepted finished wash sets the warning flag.
// - Tolerance 0 to 1440 minutes; no acceptance within it sets failure instead.
// - Accepted wash clears warning and failure and restarts the tolerance count.
// - Automatic cut ends wash two seconds after index falls below limit.
// - Measurement hold, on by default, freezes concentration and loop during cycle.
// - Temperature hold, off by default, freezes temperature during cycle.
// - Low temperature inhibit, off by default, threshold 0 to 200, blocks washing.
// - Empty-line guard, on by default, blocks washing without sample.
// - Verify limit is 1.15 to 1.80, reset value 1.35.
// - At start, limit is the higher of configured and index minus delta.
// - Pending triggers are served manual first, then external, then interval.
// - A one-second pause with both relays open follows precondition.
// - Recovery runs after wash before the cycle ends and holds release.
// - While wash stop is active no relay is closed.
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`default_nettype none
module pws_top import pws_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_clean_request,
  input wire logic external_wash_stop,
  input wire logic no_sample,
  input wire logic no_sensor,
  input wire logic sensor_fault,
  input wire logic [15:0] refractive_index,
  input wire pws_meas_t meas_in,
  output pws_meas_t meas_out,
  output logic precond_relay,
  output logic wash_relay,
  output logic wash_warning,
  output logic wash_failure
);
  pws_state_t r, n;

  // Clamps a written value into its documented range.
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Merges the low halfword of a write under its byte strobes.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // Advances a seconds and minutes count by one second, carrying into the minutes.
  function automatic logic [16:0] min_step(input logic [5:0] sec, input logic [10:0] mins);
    min_step = (sec == SEC_PER_MIN - 6'h01) ? {6'h00, mins + 11'h001} : {sec + 6'h01, mins};
  endfunction

  logic enabled, inhibit, start, below, low_temp, cyc_next;
  logic [15:0] tmp_lim;
  logic [16:0] istep, tstep;
  pws_vmode_t vmode;

  // Gating terms; a no-sample inhibit follows the guard so the operator can lift it.
  always_comb begin
    vmode = pws_vmode_t'(r.ctrl[C_VM +: 2]);
    enabled = (r.wash_t != 16'h0000) && r.ctrl[C_WASH_RLY];
    low_temp = r.ctrl[C_LOWT] && ($signed(meas_in.temp) < $signed(r.temp_lim));
    inhibit = (no_sample && r.ctrl[C_GUARD]) || no_sensor || sensor_fault
              || external_wash_stop || low_temp;
    start = (r.ph == ST_IDLE) && enabled && !inhibit && (r.man_p || r.ext_p || r.int_p);
    below = refractive_index < r.lim;
    tmp_lim = (refractive_index > r.delta) ? refractive_index - r.delta : 16'h0000;
    istep = min_step(r.int_sec, r.int_min);
    tstep = min_step(r.tol_sec, r.tol_min);
  end

  // Whole next state: bus slave, settings, timers, sequencer and outputs.
  always_comb begin
    n = r;
    cyc_next = 1'b0;
    // Prescaler for the one-second tick.
    n.tick = (r.presc == TICK_CYCLES - 1);
    n.presc = n.tick ? 32'h0 : r.presc + 32'h1;
    // Write channel: address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_have = 1'b1;
      n.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_have = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) n.bvalid = 1'b0;
    if (r.aw_have && r.w_have && !r.bvalid) begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OK;
      unique case (r.awaddr)
        A_CTRL: begin
          if (r.wstrb[0]) n.ctrl[7:0] = r.wdata[7:0];
          if (r.wstrb[1]) n.ctrl[9:8] = r.wdata[9:8];
          n.ctrl[C_MANUAL] = 1'b0;
          if (r.wstrb[0] && r.wdata[C_MANUAL] && enabled) n.man_p = 1'b1;
        end
        A_PRE: n.pre_t = clamp(merge(r.pre_t, r.wdata, r.wstrb), 16'h0000, PRE_MAX);
        A_REC: n.rec_t = clamp(merge(r.rec_t, r.wdata, r.wstrb), 16'h0000, REC_MAX);
        A_WASH: n.wash_t = clamp(merge(r.wash_t, r.wdata, r.wstrb), 16'h0000, WASH_MAX);
        A_INT: n.int_t = clamp(merge(r.int_t, r.wdata, r.wstrb), 16'h0000, INT_MAX);
        A_TOL: n.tol_t = clamp(merge(r.tol_t, r.wdata, r.wstrb), 16'h0000, TOL_MAX);
        A_TEMP: n.temp_lim = clamp(merge(r.temp_lim, r.wdata, r.wstrb), 16'h0000, TEMP_MAX);
        A_VLIM: n.vlim = clamp(merge(r.vlim, r.wdata, r.wstrb), VLIM_MIN, VLIM_MAX);
        A_DELTA: n.delta = clamp(merge(r.delta, r.wdata, r.wstrb), 16'h0000, DELTA_MAX);
        A_STAT: n.bresp = RESP_OK;
        default: n.bresp = RESP_DEC;
      endcase
    end
    // Read channel answers one cycle after the address is taken.
    if (r.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OK;
      n.rdata = 32'h0;
      unique case (s_axi_araddr[7:0])
        A_CTRL: n.rdata = {22'h0, r.ctrl};
        A_PRE: n.rdata = {16'h0, r.pre_t};
        A_REC: n.rdata = {16'h0, r.rec_t};
        A_WASH: n.rdata = {16'h0, r.wash_t};
        A_INT: n.rdata = {16'h0, r.int_t};
        A_TOL: n.rdata = {16'h0, r.tol_t};
        A_TEMP: n.rdata = {16'h0, r.temp_lim};
        A_VLIM: n.rdata = {16'h0, r.vlim};
        A_DELTA: n.rdata = {16'h0, r.delta};
        A_STAT: n.rdata = {r.tol_min, r.int_min, inhibit, enabled, r.src, r.fail, r.warn,
                           r.accepted, r.ph};
        default: n.rresp = RESP_DEC;
      endcase
    end
    // Trigger capture; an edge on the external request is needed for each cycle.
    n.ext_prev = external_clean_request;
    if (external_clean_request && !r.ext_prev && enabled) n.ext_p = 1'b1;
    if (r.tick && r.ph == ST_IDLE) begin
      n.int_sec = istep[16:11];
      n.int_min = istep[10:0];
    end
    if (r.int_t != 16'h0000 && r.int_min >= r.int_t[10:0] && enabled) n.int_p = 1'b1;
    if (r.int_t == 16'h0000 || !enabled) n.int_p = 1'b0;
    if (!enabled) begin
      n.man_p = 1'b0;
      n.ext_p = 1'b0;
    end
    // Tolerance time runs in minutes since the last accepted wash.
    if (r.tick && r.tol_min != 11'h7FF) begin
      n.tol_sec = tstep[16:11];
      n.tol_min = tstep[10:0];
    end
    if (r.tick && r.ph != ST_IDLE) n.ph_cnt = r.ph_cnt + 8'h01;
    if (below && r.ph != ST_IDLE) n.accepted = 1'b1;
    if (no_sample && r.ph != ST_IDLE) n.accepted = 1'b1;
    // Phase sequencer.
    unique case (r.ph)
      ST_IDLE: if (start) begin
        // Manual first, then external, then interval; the served one is consumed.
        if (r.man_p) begin
          n.man_p = 1'b0;
          n.src = 2'h1;
        end else if (r.ext_p) begin
          n.ext_p = 1'b0;
          n.src = 2'h2;
        end else begin
          n.int_p = 1'b0;
          n.src = 2'h3;
        end
        n.int_sec = 6'h00;
        n.int_min = 11'h000;
        n.lim = (tmp_lim > r.vlim) ? tmp_lim : r.vlim;
        n.accepted = 1'b0;
        n.cut_armed = 1'b0;
        n.ph_cnt = 8'h00;
        n.ph = (r.pre_t == 16'h0000 || !r.ctrl[C_PRE_RLY]) ? ST_WASH : ST_PRE;
      end
      ST_PRE: if (r.ph_cnt >= r.pre_t[7:0]) begin
        n.ph = ST_PAUSE;
        n.ph_cnt = 8'h00;
      end
      ST_PAUSE: if (r.ph_cnt >= PAUSE_S) begin
        n.ph = ST_WASH;
        n.ph_cnt = 8'h00;
      end
      ST_WASH: begin
        if (vmode == VM_CUT && below && !r.cut_armed) begin
          n.cut_armed = 1'b1;
          n.cut_cnt = 2'h0;
        end
        if (r.cut_armed && r.tick) n.cut_cnt = r.cut_cnt + 2'h1;
        if (r.ph_cnt >= r.wash_t[7:0] || (r.cut_armed && r.cut_cnt >= CUT_S)) begin
          n.ph = ST_REC;
          n.ph_cnt = 8'h00;
        end
      end
      ST_REC: if (r.ph_cnt >= r.rec_t[7:0]) begin
        n.ph = ST_IDLE;
        if (vmode == VM_STD || vmode == VM_CUT) begin
          if (n.accepted) begin
            n.warn = 1'b0;
            n.fail = 1'b0;
            n.tol_sec = 6'h00;
            n.tol_min = 11'h000;
          end else if (r.tol_min >= r.tol_t[10:0]) begin
            n.fail = 1'b1;
            n.warn = 1'b0;
          end else begin
            n.warn = 1'b1;
          end
        end
      end
      default: n.ph = ST_IDLE;
    endcase
    // Relays follow the next phase and open at once on a wash stop.
    n.pre_rly = (n.ph == ST_PRE) && !external_wash_stop;
    n.wash_rly = (n.ph == ST_WASH) && !external_wash_stop;
    // Holds freeze the value taken just before the cycle began.
    cyc_next = (n.ph != ST_IDLE);
    if (!(cyc_next && r.ctrl[C_MHOLD])) begin
      n.mout.concentration_reading = meas_in.concentration_reading;
      n.mout.loop = meas_in.loop;
    end
    if (!(cyc_next && r.ctrl[C_THOLD])) n.mout.temp = meas_in.temp;
  end

  // State register with reset values for every setting and flag.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.ph <= ST_IDLE;
      r.ctrl <= CTRL_DEF;
      r.pre_t <= PRE_DEF;
      r.rec_t <= REC_DEF;
      r.wash_t <= WASH_DEF;
      r.int_t <= INT_DEF;
      r.tol_t <= TOL_DEF;
      r.temp_lim <= TEMP_DEF;
      r.vlim <= VLIM_DEF;
      r.delta <= DELTA_DEF;
      r.lim <= VLIM_DEF;
    end else begin
      r <= n;
    end
  end

  // Ready outputs are combinational; valid, response and data outputs come straight from flops.
  assign s_axi_awready = !r.aw_have && !r.bvalid;
  assign s_axi_wready = !r.w_have && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign meas_out = r.mout;
  assign precond_relay = r.pre_rly;
  assign wash_relay = r.wash_rly;
  assign wash_warning = r.warn;
  assign wash_failure = r.fail;

  a_relays_apart: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(precond_relay) |-> !wash_relay [*2]) else $error("Relays overlap after precondition.");
  a_stop_opens: assert property (@(posedge aclk) disable iff (!aresetn)
    external_wash_stop |=> !precond_relay && !wash_relay) else $error("Relay closed on stop.");
  a_disabled_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.ph == ST_IDLE && !enabled) |=> r.ph == ST_IDLE) else $error("Cycle started while off.");
  a_ext_one_shot: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.ext_prev && external_clean_request && !r.ext_p) |=> !r.ext_p)
    else $error("Held request rearmed.");
  a_zero_interval: assert property (@(posedge aclk) disable iff (!aresetn)
    r.int_t == 16'h0000 |=> !r.int_p) else $error("Zero interval raised a trigger.");
  a_hold_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.ph != ST_IDLE && $past(r.ph) != ST_IDLE && r.ctrl[C_MHOLD]) |-> $stable(meas_out.concentration_reading))
    else $error("Concentration moved during hold.");
  a_flags_apart: assert property (@(posedge aclk) disable iff (!aresetn)
    !(wash_warning && wash_failure)) else $error("Warning and failure both set.");
  a_inhibit_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (r.ph == ST_IDLE && (no_sensor || sensor_fault)) |=> r.ph == ST_IDLE)
    else $error("Cycle started while inhibited.");
  a_manual_first: assert property (@(posedge aclk) disable iff (!aresetn)
    (start && r.man_p) |=> r.src == 2'h1) else $error("Manual request not served first.");
  a_reset_values: assert property (@(posedge aclk)
    !aresetn |=> r.wash_t == WASH_DEF && r.rec_t == REC_DEF && r.int_t == INT_DEF)
    else $error("Reset values wrong.");
endmodule
`default_nettype wire

// ---- dv/pws_plant.sv ----
`default_nettype none
module pws_plant import pws_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wash_relay,
  input wire logic [15:0] idx_proc,
  input wire logic [15:0] idx_wash,
  output logic [15:0] refractive_index,
  output pws_meas_t meas_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Concentration and loop drift every cycle, so a frozen output cannot pass for a live one by chance; temperature stays at 25.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_in <= '0;
    end else begin
      meas_in.concentration_reading <= meas_in.concentration_reading + 16'h0001;
      meas_in.loop <= meas_in.loop + 16'h0003;
      meas_in.temp <= 16'h0019;
    end
  end
  // Wash medium on the prism lowers the index only while the wash relay is closed.
  assign refractive_index = wash_relay ? idx_wash : idx_proc;
endmodule
`default_nettype wire

// ---- dv/tb_pws_top.sv ----
`default_nettype none
module tb_pws_top import pws_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, awv, wv, bready, arv, rready, ext, stop, nos, nsen, sflt;
  logic awready, wready, bvalid, arready, rvalid, pre_r, wash_r, warn, fail;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [15:0] idx, idxw, ri;
  pws_meas_t mi, mo;
  int fail_count = 0;
  int checks = 0;
  int rises = 0;
  int tn = 0;
  logic [7:0] ra [9] = '{A_CTRL, A_PRE, A_REC, A_WASH, A_INT, A_TOL, A_TEMP, A_VLIM, A_DELTA};
  logic [15:0] rv [9] = '{16'h001E, 16'h0000, 16'h0014, 16'h0003, 16'h0014, 16'h0000,
    16'h0000, 16'h34BC, 16'h0000};
  logic [15:0] rmx [9] = '{16'h0000, 16'h003C, 16'h0078, 16'h001E, 16'h05A0, 16'h05A0,
    16'h00C8, 16'h4650, 16'h1388};

  pws_top #(.TICK_CYCLES(10)) i_pws_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_clean_request(ext), .external_wash_stop(stop), .no_sample(nos),
    .no_sensor(nsen), .sensor_fault(sflt), .refractive_index(ri), .meas_in(mi),
    .meas_out(mo), .precond_relay(pre_r), .wash_relay(wash_r), .wash_warning(warn),
    .wash_failure(fail));
  pws_plant i_pws_plant (.aclk(aclk), .aresetn(aresetn), .wash_relay(wash_r),
    .idx_proc(idx), .idx_wash(idxw), .refractive_index(ri), .meas_in(mi));

  // Clock of 25 ns period.
  initial begin
    aclk = 1'h0;
    forever #12.5 aclk = ~aclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ready is sampled at the falling edge, so the decision never races the rising edge.
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, db;
    @(posedge aclk);
    awaddr <= {24'h000000, a};
    wdata <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bready <= 1'h1;
    db = 1'h0;
    while (!db) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      db = bvalid;
      @(posedge aclk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
    end
    bready <= 1'h0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, dv;
    @(posedge aclk);
    araddr <= {24'h000000, a};
    arv <= 1'h1;
    rready <= 1'h1;
    dv = 1'h0;
    while (!dv) begin
      @(negedge aclk);
      ta = arready;
      dv = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arv <= 1'h0;
    end
    rready <= 1'h0;
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask

  task src(input logic [1:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(A_STAT, d, r);
    chk({30'h00000000, d[7:6]}, {30'h00000000, e});
  endtask

  // Waits a bounded time for a relay to reach a level, then returns on a rising edge.
  task wt(input bit p, input logic v, input int n);
    int k;
    k = 0;
    while ((p ? pre_r : wash_r) !== v && k < n) begin
      @(negedge aclk);
      k++;
    end
    chk({31'h00000000, p ? pre_r : wash_r}, {31'h00000000, v});
    @(posedge aclk);
  endtask

  // Polling the phase avoids guessing how long recovery lasts.
  task idle;
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h00000001;
    for (int k = 0; k < 60 && d[2:0] != 3'h0; k++) rd(A_STAT, d, r);
  endtask

  task fin;
    tn++;
    $display("Test %0d finished", tn);
  endtask

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Count closures of the wash relay and flag any overlap with precondition.
  always @(posedge wash_r) rises++;
  always @(negedge aclk) if (pre_r === 1'h1 && wash_r === 1'h1) chk(32'h1, 32'h0);

  initial begin
    repeat (60000) @(posedge aclk);
    fail_count++;
    print_verdict;
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int k;
    {aresetn, awv, wv, bready, arv, rready, ext, stop, nos, nsen, sflt} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    idx = 16'h3A98;
    idxw = 16'h3A98;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 9; i++) rc(ra[i], {16'h0000, rv[i]});
    rd(8'h40, d, r);
    chk({30'h00000000, r}, 32'h00000003);
    for (int i = 1; i < 9; i++) begin
      wr(ra[i], 32'h0000FFFF);
      rc(ra[i], {16'h0000, rmx[i]});
      wr(ra[i], {16'h0000, rv[i]});
    end
    wr(A_INT, 32'h00000000);
    wr(A_REC, 32'h00000002);
    fin;
    // One held request gives one cycle; no interval start with a zero interval.
    ext <= 1'h1;
    wt(0, 1'h1, 100);
    chk({31'h00000000, pre_r}, 32'h00000000);
    idle;
    repeat (300) @(posedge aclk);
    chk(rises, 32'h00000001);
    src(2'h2);
    ext <= 1'h0;
    fin;
    // Both requests wait behind wash stop, then run in priority order.
    stop <= 1'h1;
    @(posedge aclk);
    ext <= 1'h1;
    wr(A_CTRL, 32'h0000001F);
    k = rises;
    repeat (100) @(posedge aclk);
    chk(rises, k);
    stop <= 1'h0;
    wt(0, 1'h1, 100);
    src(2'h1);
    wt(0, 1'h0, 200);
    wt(0, 1'h1, 200);
    src(2'h2);
    idle;
    ext <= 1'h0;
    fin;
    // Precondition, then a pause with both relays open.
    wr(A_PRE, 32'h00000002);
    wr(A_CTRL, 32'h0000001F);
    wt(1, 1'h1, 100);
    wt(1, 1'h0, 100);
    chk({31'h00000000, wash_r}, 32'h00000000);
    wt(0, 1'h1, 50);
    idle;
    wr(A_PRE, 32'h00000000);
    fin;
    // A missing sensor holds the request back until it returns.
    nsen <= 1'h1;
    wr(A_CTRL, 32'h0000001F);
    k = rises;
    repeat (100) @(posedge aclk);
    chk(rises, k);
    nsen <= 1'h0;
    wt(0, 1'h1, 100);
    idle;
    fin;
    // Standard verify: a large delta keeps the configured limit, so the wash fails.
    idxw = 16'h3800;
    wr(A_DELTA, 32'h00001388);
    wr(A_CTRL, 32'h0000011F);
    wt(0, 1'h1, 100);
    d = {16'h0000, mo.concentration_reading};
    repeat (5) @(posedge aclk);
    chk({16'h0000, mo.concentration_reading}, d);
    idle;
    chk({31'h00000000, fail}, 32'h00000001);
    wr(A_DELTA, 32'h00000000);
    wr(A_CTRL, 32'h0000011F);
    wt(0, 1'h1, 100);
    idle;
    chk({30'h00000000, warn, fail}, 32'h00000000);
    fin;
    // Automatic cut ends a 30 s wash about 2 s after the index drops.
    idxw = 16'h2000;
    wr(A_WASH, 32'h0000001E);
    wr(A_CTRL, 32'h0000021F);
    wt(0, 1'h1, 100);
    for (k = 0; k < 400 && wash_r === 1'h1; k++) @(posedge aclk);
    chk({31'h00000000, k <= 40}, 32'h00000001);
    idle;
    fin;
    // Zero wash time ignores requests; then a one-minute interval starts a cycle.
    wr(A_WASH, 32'h00000000);
    wr(A_CTRL, 32'h0000001F);
    k = rises;
    repeat (100) @(posedge aclk);
    chk(rises, k);
    wr(A_WASH, 32'h00000003);
    wr(A_CTRL, 32'h0000001E);
    wr(A_INT, 32'h00000001);
    wt(0, 1'h1, 900);
    src(2'h3);
    fin;
    print_verdict;
  end
endmodule
`default_nettype wire
